/* File: verilog/sibw_map.svh */
// How it works
// - Internal SDA lags SCL by a hold time set in 50 ns steps, default one.
// - SCL and SDA pulses up to a 10 ns-step width, default seven, are rejected.
// - As local bus master, SCL stays high for the high count of 50 ns units.
// - As local bus master, SCL stays low for the low count of 50 ns units.
// - When stretching as slave, SDA gets the low count as setup before SCL release.
// - SCL high and low times are counted in internal oscillator cycles.
// - A 2-bit field picks the fallback oscillator frequency, reset value zero.
// - Self-test mode follows the self-test enable bit, which resets to zero.
// - A control-channel transaction still open at watchdog expiry is aborted.
// - Watchdog timeout is a 7-bit count of 2 ms units, reset value 0x7F.
// - A disable bit stops the watchdog; it resets to zero so the watchdog runs.
// - In self-test, back-channel CRC errors are counted in an 8-bit read-only counter.
`ifndef SIBW_MAP_SVH
`define SIBW_MAP_SVH

`define SIBW_ADDR_INPUT_COND    8'h10
`define SIBW_ADDR_SCL_HIGH      8'h11
`define SIBW_ADDR_SCL_LOW       8'h12
`define SIBW_ADDR_GP_BITS       8'h13
`define SIBW_ADDR_SELF_TEST     8'h14
`define SIBW_ADDR_WDOG_CTRL     8'h1E
`define SIBW_ADDR_CRC_ERR_CNT   8'h2A

`define SIBW_RST_HOLD_TIME      3'h1
`define SIBW_RST_FILTER_DEPTH   4'h7
`define SIBW_RST_SCL_HIGH       8'h82
`define SIBW_RST_SCL_LOW        8'h82
`define SIBW_RST_GP_BITS        8'h00
`define SIBW_RST_CLK_SRC        2'h0
`define SIBW_RST_WDOG_TIMEOUT   7'h7F
`define SIBW_RST_BIST_EN        1'b0
`define SIBW_RST_WDOG_DIS       1'b0
`define SIBW_RST_CRC_ERR        8'h00

`define SIBW_FLD_HOLD_MSB       6
`define SIBW_FLD_HOLD_LSB       4
`define SIBW_FLD_FILT_MSB       3
`define SIBW_FLD_FILT_LSB       0
`define SIBW_FLD_CLKSRC_MSB     2
`define SIBW_FLD_CLKSRC_LSB     1
`define SIBW_FLD_BIST_EN        0
`define SIBW_FLD_WDOG_MSB       7
`define SIBW_FLD_WDOG_LSB       1
`define SIBW_FLD_WDOG_DIS       0

`define SIBW_CLK_PERIOD_PS      8000
`define SIBW_FILT_STEP_PS       10000
`define SIBW_HOLD_STEP_PS       50000
`define SIBW_CLK_PERIOD_NS      8
`define SIBW_WDOG_UNIT_NS       2000000

`endif

/* File: verilog/sibw_pkg.sv */
package sibw_pkg;

  typedef logic [7:0] sibw_byte_t;

  typedef enum logic [2:0] {
    SCL_IDLE,
    SCL_HIGH,
    SCL_LOW,
    SCL_HOLD,
    SCL_SETUP
  } sibw_scl_state_e;

endpackage : sibw_pkg

/* File: verilog/sibw_pin_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module sibw_pin_filter #(
  parameter int REJ_W   = 5,
  parameter int DLY_W   = 6
) (
  input  wire logic             clk,        // Block clock.
  input  wire logic             srst,       // Synchronous reset, active high.
  input  wire logic             ce,         // Clock enable.
  input  wire logic             pin,        // Raw pin level.
  input  wire logic [REJ_W-1:0] rej_cycles, // Widest pulse rejected, in clocks.
  input  wire logic [DLY_W-1:0] dly_cycles, // Extra delay, in clocks.
  output logic                  out         // Cleaned, delayed level.
);
  localparam int DEPTH = 1 << DLY_W;

  if (REJ_W < 1 || DLY_W < 1) $error("sibw_pin_filter: bad widths");

  logic [2:0]       sync_q, sync_d;
  logic             lvl_q, lvl_d;
  logic [REJ_W-1:0] run_q, run_d;
  logic             clean_q, clean_d;
  logic [DEPTH-1:0] line_q, line_d;
  logic             out_d;

  always_comb
  begin
    sync_d  = {sync_q[1:0], pin};
    lvl_d   = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    run_d   = run_q;
    clean_d = clean_q;
    // A level must outlast the reject width before it is believed.
    if (lvl_q == clean_q)
      run_d = '0;
    else if (run_q >= rej_cycles)
    begin
      clean_d = lvl_q;
      run_d   = '0;
    end
    else
      run_d = run_q + 1'b1;
    line_d = {line_q[DEPTH-2:0], clean_q};
    out_d  = (dly_cycles == '0) ? clean_q : line_q[dly_cycles - 1'b1];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_q  <= 3'h7;
      lvl_q   <= 1'b1;
      run_q   <= '0;
      clean_q <= 1'b1;
      line_q  <= '1;
      out     <= 1'b1;
    end
    else if (ce)
    begin
      sync_q  <= sync_d;
      lvl_q   <= lvl_d;
      run_q   <= run_d;
      clean_q <= clean_d;
      line_q  <= line_d;
      out     <= out_d;
    end
  end

endmodule : sibw_pin_filter
`default_nettype wire

/* File: verilog/sibw_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sibw_map.svh"
module sibw_regs #(
  parameter int WDOG_UNIT_CYCLES = `SIBW_WDOG_UNIT_NS / `SIBW_CLK_PERIOD_NS
) (
  input  wire logic       REF_CLK,        // Block clock, 125 MHz.
  input  wire logic       SRST,           // Synchronous reset, active high.
  input  wire logic       CE,             // Clock enable; low freezes all state.
  input  wire logic [7:0] REG_ADDR,       // Register address from the serial slave.
  input  wire logic [7:0] REG_WDATA,      // Write data.
  input  wire logic       REG_WE,         // Write strobe, one cycle.
  input  wire logic       REG_RE,         // Read strobe, one cycle.
  output logic      [7:0] REG_RDATA,      // Read data, valid the cycle after REG_RE.
  input  wire logic       SCL_IN,         // SCL pin level.
  input  wire logic       SDA_IN,         // SDA pin level.
  output logic            SCL_FILT,       // Filtered SCL seen by the slave.
  output logic            SDA_FILT,       // Filtered, hold-delayed SDA.
  input  wire logic       OSC_CLK,        // Internal oscillator, sampled.
  input  wire logic       MST_RUN,        // Local master wants SCL clocks.
  input  wire logic       SLV_HOLD,       // Slave stretches SCL while high.
  output logic            SCL_OUT,        // SCL drive value (always low).
  output logic            SCL_OE,         // SCL drive enable; high pulls low.
  output logic            SLV_RELEASED,   // Pulse: stretch ended, SCL released.
  output logic      [7:0] GP_BITS,        // General-purpose control bits.
  output logic      [1:0] OSC_FREQ_SEL,   // Fallback oscillator frequency choice.
  output logic            BIST_MODE,      // Self-test mode active.
  input  wire logic       BC_CRC_ERR,     // Pulse: back-channel CRC error.
  input  wire logic       XACT_BUSY,      // Control-channel transaction open.
  output logic            XACT_ABORT      // Pulse: transaction aborted by watchdog.
);
  localparam int PRE_W = $clog2(WDOG_UNIT_CYCLES + 1);
  localparam int REJ_W = 5;
  localparam int DLY_W = 6;

  if (WDOG_UNIT_CYCLES < 1) $error("sibw_regs: watchdog unit below one cycle");

  // Register state.
  logic [2:0]  hold_q, hold_d;
  logic [3:0]  filt_q, filt_d;
  logic [7:0]  hi_q, hi_d, lo_q, lo_d, gp_d;
  logic [1:0]  clksrc_d;
  logic        bist_d;
  logic [6:0]  wto_q, wto_d;
  logic        wdis_q, wdis_d;
  logic [7:0]  crc_q, crc_d;
  logic [7:0]  rdata_d;

  always_comb
  begin
    hold_d   = hold_q;
    filt_d   = filt_q;
    hi_d     = hi_q;
    lo_d     = lo_q;
    gp_d     = GP_BITS;
    clksrc_d = OSC_FREQ_SEL;
    bist_d   = BIST_MODE;
    wto_d    = wto_q;
    wdis_d   = wdis_q;
    crc_d    = crc_q;
    rdata_d  = REG_RDATA;
    if (REG_WE)
    begin
      unique case (REG_ADDR)
        `SIBW_ADDR_INPUT_COND:
        begin
          hold_d = REG_WDATA[`SIBW_FLD_HOLD_MSB:`SIBW_FLD_HOLD_LSB];
          filt_d = REG_WDATA[`SIBW_FLD_FILT_MSB:`SIBW_FLD_FILT_LSB];
        end
        `SIBW_ADDR_SCL_HIGH: hi_d = REG_WDATA;
        `SIBW_ADDR_SCL_LOW:  lo_d = REG_WDATA;
        `SIBW_ADDR_GP_BITS:  gp_d = REG_WDATA;
        `SIBW_ADDR_SELF_TEST:
        begin
          clksrc_d = REG_WDATA[`SIBW_FLD_CLKSRC_MSB:`SIBW_FLD_CLKSRC_LSB];
          bist_d   = REG_WDATA[`SIBW_FLD_BIST_EN];
        end
        `SIBW_ADDR_WDOG_CTRL:
        begin
          wto_d  = REG_WDATA[`SIBW_FLD_WDOG_MSB:`SIBW_FLD_WDOG_LSB];
          wdis_d = REG_WDATA[`SIBW_FLD_WDOG_DIS];
        end
        default: ;
      endcase
    end
    // Counting stops at the top so a long run still reads as many errors.
    if (bist_d && !BIST_MODE)
      crc_d = '0;
    else if (BIST_MODE && BC_CRC_ERR && crc_q != '1)
      crc_d = crc_q + 1'b1;
    if (REG_RE)
    begin
      unique case (REG_ADDR)
        `SIBW_ADDR_INPUT_COND: rdata_d = {1'b0, hold_q, filt_q};
        `SIBW_ADDR_SCL_HIGH:   rdata_d = hi_q;
        `SIBW_ADDR_SCL_LOW:    rdata_d = lo_q;
        `SIBW_ADDR_GP_BITS:    rdata_d = GP_BITS;
        `SIBW_ADDR_SELF_TEST:  rdata_d = {5'h00, OSC_FREQ_SEL, BIST_MODE};
        `SIBW_ADDR_WDOG_CTRL:  rdata_d = {wto_q, wdis_q};
        `SIBW_ADDR_CRC_ERR_CNT: rdata_d = crc_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      hold_q       <= `SIBW_RST_HOLD_TIME;
      filt_q       <= `SIBW_RST_FILTER_DEPTH;
      hi_q         <= `SIBW_RST_SCL_HIGH;
      lo_q         <= `SIBW_RST_SCL_LOW;
      GP_BITS      <= `SIBW_RST_GP_BITS;
      OSC_FREQ_SEL <= `SIBW_RST_CLK_SRC;
      BIST_MODE    <= `SIBW_RST_BIST_EN;
      wto_q        <= `SIBW_RST_WDOG_TIMEOUT;
      wdis_q       <= `SIBW_RST_WDOG_DIS;
      crc_q        <= `SIBW_RST_CRC_ERR;
      REG_RDATA    <= 8'h00;
    end
    else if (CE)
    begin
      hold_q       <= hold_d;
      filt_q       <= filt_d;
      hi_q         <= hi_d;
      lo_q         <= lo_d;
      GP_BITS      <= gp_d;
      OSC_FREQ_SEL <= clksrc_d;
      BIST_MODE    <= bist_d;
      wto_q        <= wto_d;
      wdis_q       <= wdis_d;
      crc_q        <= crc_d;
      REG_RDATA    <= rdata_d;
    end
  end

  // Step widths turned into clocks; rejection rounds up, the hold too.
  function automatic int steps_to_cycles(input int steps, input int step_ps);
    steps_to_cycles = (steps * step_ps + `SIBW_CLK_PERIOD_PS - 1) / `SIBW_CLK_PERIOD_PS;
  endfunction : steps_to_cycles

  logic [REJ_W-1:0] rej_cycles;
  logic [DLY_W-1:0] dly_cycles;

  always_comb
  begin
    rej_cycles = REJ_W'(steps_to_cycles(int'(filt_q), `SIBW_FILT_STEP_PS));
    dly_cycles = DLY_W'(steps_to_cycles(int'(hold_q), `SIBW_HOLD_STEP_PS));
  end

  sibw_pin_filter #(.REJ_W(REJ_W), .DLY_W(DLY_W)) u_scl_filt (
    .clk        (REF_CLK),
    .srst       (SRST),
    .ce         (CE),
    .pin        (SCL_IN),
    .rej_cycles (rej_cycles),
    .dly_cycles ('0),
    .out        (SCL_FILT)
  );

  sibw_pin_filter #(.REJ_W(REJ_W), .DLY_W(DLY_W)) u_sda_filt (
    .clk        (REF_CLK),
    .srst       (SRST),
    .ce         (CE),
    .pin        (SDA_IN),
    .rej_cycles (rej_cycles),
    .dly_cycles (dly_cycles),
    .out        (SDA_FILT)
  );

  // Oscillator sampling; an edge counts once two late stages agree.
  logic [2:0] osc_sync_q, osc_sync_d;
  logic       osc_lvl_q, osc_lvl_d;
  logic       osc_rise;

  always_comb
  begin
    osc_sync_d = {osc_sync_q[1:0], OSC_CLK};
    osc_lvl_d  = (osc_sync_q[1] == osc_sync_q[2]) ? osc_sync_q[2] : osc_lvl_q;
    osc_rise   = osc_lvl_d && !osc_lvl_q;
  end

  // SCL timing engine, counted in oscillator periods so the nominal unit is 50 ns.
  sibw_pkg::sibw_scl_state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic       oe_d, rel_d;

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    rel_d = 1'b0;
    unique case (st_q)
      sibw_pkg::SCL_IDLE:
      begin
        if (SLV_HOLD)
          st_d = sibw_pkg::SCL_HOLD;
        else if (MST_RUN)
        begin
          st_d  = sibw_pkg::SCL_HIGH;
          cnt_d = hi_q;
        end
      end
      sibw_pkg::SCL_HIGH:
      begin
        if (osc_rise)
        begin
          if (cnt_q <= 8'h01)
          begin
            st_d  = sibw_pkg::SCL_LOW;
            cnt_d = lo_q;
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
      end
      sibw_pkg::SCL_LOW:
      begin
        if (osc_rise)
        begin
          if (cnt_q <= 8'h01)
          begin
            st_d  = MST_RUN ? sibw_pkg::SCL_HIGH : sibw_pkg::SCL_IDLE;
            cnt_d = hi_q;
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
      end
      sibw_pkg::SCL_HOLD:
      begin
        // Data is now on SDA; keep SCL low for the setup span.
        if (!SLV_HOLD)
        begin
          st_d  = sibw_pkg::SCL_SETUP;
          cnt_d = lo_q;
        end
      end
      sibw_pkg::SCL_SETUP:
      begin
        if (osc_rise)
        begin
          if (cnt_q <= 8'h01)
          begin
            st_d  = sibw_pkg::SCL_IDLE;
            rel_d = 1'b1;
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = sibw_pkg::SCL_IDLE;
    endcase
    oe_d = (st_d == sibw_pkg::SCL_LOW) || (st_d == sibw_pkg::SCL_HOLD) ||
           (st_d == sibw_pkg::SCL_SETUP);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      osc_sync_q   <= 3'h0;
      osc_lvl_q    <= 1'b0;
      st_q         <= sibw_pkg::SCL_IDLE;
      cnt_q        <= 8'h00;
      SCL_OE       <= 1'b0;
      SCL_OUT      <= 1'b0;
      SLV_RELEASED <= 1'b0;
    end
    else if (CE)
    begin
      osc_sync_q   <= osc_sync_d;
      osc_lvl_q    <= osc_lvl_d;
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      SCL_OE       <= oe_d;
      SCL_OUT      <= 1'b0;
      SLV_RELEASED <= rel_d;
    end
  end

  // Control-channel watchdog. A zero timeout is left to software to avoid;
  // here it would abort on the first unit tick.
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [6:0]       units_q, units_d;
  logic             fired_q, fired_d;
  logic             abort_d;

  always_comb
  begin
    pre_d   = pre_q;
    units_d = units_q;
    fired_d = fired_q;
    abort_d = 1'b0;
    if (!XACT_BUSY || wdis_q)
    begin
      pre_d   = '0;
      units_d = '0;
      fired_d = 1'b0;
    end
    else if (!fired_q)
    begin
      if (pre_q == PRE_W'(WDOG_UNIT_CYCLES - 1))
      begin
        pre_d   = '0;
        units_d = units_q + 1'b1;
        if (units_d >= wto_q)
        begin
          abort_d = 1'b1;
          fired_d = 1'b1;
        end
      end
      else
        pre_d = pre_q + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pre_q      <= '0;
      units_q    <= 7'h00;
      fired_q    <= 1'b0;
      XACT_ABORT <= 1'b0;
    end
    else if (CE)
    begin
      pre_q      <= pre_d;
      units_q    <= units_d;
      fired_q    <= fired_d;
      XACT_ABORT <= abort_d;
    end
  end

endmodule : sibw_regs
`default_nettype wire

/* File: dv/sibw_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sibw_regs_chk (
  input wire logic       REF_CLK,      // Clock.
  input wire logic       SRST,         // Reset.
  input wire logic       CE,           // Enable.
  input wire logic [7:0] REG_ADDR,     // Address.
  input wire logic [7:0] REG_WDATA,    // Write data.
  input wire logic       REG_WE,       // Write strobe.
  input wire logic       REG_RE,       // Read strobe.
  input wire logic [7:0] REG_RDATA,    // Read data.
  input wire logic       SCL_OUT,      // SCL drive value.
  input wire logic       SCL_OE,       // SCL enable.
  input wire logic       SLV_RELEASED, // Stretch end.
  input wire logic [7:0] GP_BITS,      // General bits.
  input wire logic [1:0] OSC_FREQ_SEL, // Oscillator choice.
  input wire logic       BIST_MODE,    // Self-test.
  input wire logic       XACT_BUSY,    // Transaction open.
  input wire logic       XACT_ABORT    // Abort pulse.
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  wire logic wr = CE && REG_WE;
  // Reset itself is checked, so this one must not be disabled by it.
  rst_values_a: assert property (disable iff (1'b0) SRST && CE |=>
    REG_RDATA == 8'h00 && GP_BITS == 8'h00 && OSC_FREQ_SEL == 2'h0 && !BIST_MODE)
    else $error("outputs not cleared by reset");
  gp_write_a: assert property (wr && REG_ADDR == 8'h13 |=> GP_BITS == $past(REG_WDATA))
    else $error("general bits not written");
  bist_write_a: assert property (wr && REG_ADDR == 8'h14 |=>
    BIST_MODE == $past(REG_WDATA[0]) && OSC_FREQ_SEL == $past(REG_WDATA[2:1]))
    else $error("self-test control not written");
  ctrl_hold_a: assert property (!(wr && REG_ADDR == 8'h14) |=>
    $stable(BIST_MODE) && $stable(OSC_FREQ_SEL))
    else $error("self-test control changed without a write");
  rdata_hold_a: assert property (!(CE && REG_RE) |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  abort_once_a: assert property (XACT_ABORT |=> !XACT_ABORT)
    else $error("abort longer than one cycle");
  abort_cause_a: assert property (XACT_ABORT |-> $past(XACT_BUSY))
    else $error("abort without an open transaction");
  release_a: assert property (SLV_RELEASED |-> !SCL_OE && $past(SCL_OE))
    else $error("release pulse without SCL release");
  scl_drive_a: assert property (SCL_OUT == 1'b0)
    else $error("SCL drive value not low");
  ce_freeze_a: assert property (!CE |=> $stable(GP_BITS) && $stable(BIST_MODE) &&
    $stable(SCL_OE) && $stable(REG_RDATA))
    else $error("state moved while clock enable low");
endmodule : sibw_regs_chk
bind sibw_regs sibw_regs_chk chk (.REF_CLK, .SRST, .CE, .REG_ADDR, .REG_WDATA, .REG_WE,
  .REG_RE, .REG_RDATA, .SCL_OUT, .SCL_OE, .SLV_RELEASED, .GP_BITS, .OSC_FREQ_SEL,
  .BIST_MODE, .XACT_BUSY, .XACT_ABORT);
`default_nettype wire

/* File: dv/sibw_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module sibw_far_end (
  input  wire logic scl_oe,   // Device pulls SCL low.
  input  wire logic ext_low,  // Another party pulls SCL low.
  output logic      osc_clk,  // Free-running internal oscillator.
  output logic      scl_wire  // Resolved SCL line.
);
  // The oscillator runs free; its phase is kept off the block clock on purpose.
  initial
  begin
    osc_clk = 1'b0;
    #3.7;
    forever #40 osc_clk = ~osc_clk;
  end
  // Open-drain line: any party pulling wins, otherwise the pull-up.
  assign scl_wire = !(scl_oe || ext_low);
endmodule : sibw_far_end
`default_nettype wire

/* File: dv/sibw_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sibw_regs_tb;
  logic       clk, srst, ce, we, re, sda, mst, hold, crc, busy, ext_low, osc, scl;
  logic       scl_f, sda_f, scl_out, scl_oe, rel, bist, abort, re_seen;
  logic [7:0] addr, wdata, rdata, gp, v;
  logic [1:0] fsel;
  logic [7:0] exp_q[$];
  logic [7:0] ra[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h1E, 8'h2A, 8'h20};
  logic [7:0] rv[8] = '{8'h17, 8'h82, 8'h82, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h00};
  logic [7:0] rm[8] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'h00, 8'h00};
  int         err_count, check_count, cyc, seed, c;

  sibw_regs #(.WDOG_UNIT_CYCLES(8)) uut (
    .REF_CLK(clk), .SRST(srst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda),
    .SCL_FILT(scl_f), .SDA_FILT(sda_f), .OSC_CLK(osc), .MST_RUN(mst), .SLV_HOLD(hold),
    .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SLV_RELEASED(rel), .GP_BITS(gp),
    .OSC_FREQ_SEL(fsel), .BIST_MODE(bist), .BC_CRC_ERR(crc), .XACT_BUSY(busy),
    .XACT_ABORT(abort));
  sibw_far_end far (.scl_oe(scl_oe), .ext_low(ext_low), .osc_clk(osc), .scl_wire(scl));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    exp_q.push_back(want);
    @(negedge clk);
    re = 1'b0;
  endtask : rd

  task automatic pulse_crc(input int k);
    repeat (k)
    begin
      @(negedge clk);
      crc = 1'b1;
      @(negedge clk);
      crc = 1'b0;
    end
  endtask : pulse_crc

  // Counts falling edges until the signal shows the level, giving up at the limit.
  task automatic until_lvl(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : until_lvl

  always @(posedge clk)
    re_seen <= re && ce;

  always @(negedge clk)
  begin
    if (re_seen)
      check(rdata, exp_q.pop_front());
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    seed = 29986;
    {srst, ce, we, re, sda, mst, hold, crc, busy, ext_low} = 10'b11_0010_0000;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    foreach (ra[i])
      rd(ra[i], rv[i]);
    foreach (ra[i])
    begin
      v = $random(seed);
      if (ra[i] == 8'h1E && v[7:1] == 7'h00) v[1] = 1'b1;
      wr(ra[i], v);
      rd(ra[i], v & rm[i]);
    end
    wr(8'h14, 8'h00);
    wr(8'h14, 8'h01);
    check({5'h00, fsel, bist}, 8'h01);
    pulse_crc(3);
    rd(8'h2A, 8'h03);
    wr(8'h14, 8'h00);
    pulse_crc(2);
    rd(8'h2A, 8'h03);
    wr(8'h14, 8'h01);
    rd(8'h2A, 8'h00);
    pulse_crc(300);
    rd(8'h2A, 8'hFF);
    wr(8'h1E, 8'h02);
    busy = 1'b1;
    until_lvl(abort, 1'b1, 40, c);
    check(8'(c >= 7 && c <= 11), 8'h01);
    @(negedge clk);
    until_lvl(abort, 1'b1, 40, c);
    check(8'(c), 8'h28);
    busy = 1'b0;
    wr(8'h1E, 8'h03);
    busy = 1'b1;
    until_lvl(abort, 1'b1, 40, c);
    check(8'(c), 8'h28);
    busy = 1'b0;
    wr(8'h12, 8'h02);
    hold = 1'b1;
    until_lvl(scl_oe, 1'b1, 5, c);
    check(8'(c <= 2), 8'h01);
    hold = 1'b0;
    until_lvl(rel, 1'b1, 100, c);
    check(8'(c >= 8 && c <= 35), 8'h01);
    wr(8'h11, 8'h03);
    wr(8'h12, 8'h03);
    mst = 1'b1;
    until_lvl(scl_oe, 1'b1, 200, c);
    check(8'(scl_out), 8'h00);
    until_lvl(scl_oe, 1'b0, 200, c);
    check(8'(c >= 20 && c <= 42), 8'h01);
    until_lvl(scl_oe, 1'b1, 200, c);
    check(8'(c >= 20 && c <= 42), 8'h01);
    mst = 1'b0;
    repeat (100) @(negedge clk);
    check(8'(scl_oe), 8'h00);
    wr(8'h10, 8'h17);
    sda = 1'b0;
    repeat (5) @(negedge clk);
    sda = 1'b1;
    until_lvl(sda_f, 1'b0, 30, c);
    check(8'(c), 8'h1E);
    sda = 1'b0;
    until_lvl(sda_f, 1'b0, 60, c);
    check(8'(c >= 16 && c <= 26), 8'h01);
    ext_low = 1'b1;
    repeat (5) @(negedge clk);
    ext_low = 1'b0;
    until_lvl(scl_f, 1'b0, 30, c);
    check(8'(c), 8'h1E);
    wr(8'h13, 8'h5A);
    ce = 1'b0;
    wr(8'h13, 8'hA5);
    ce = 1'b1;
    rd(8'h13, 8'h5A);
    repeat (4) @(negedge clk);
    summarize();
  end
endmodule : sibw_regs_tb
`default_nettype wire
